// >>> sif_pkg.sv
package sif_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] SIF_FLAGS_OFS = 12'h040;
  localparam logic [11:0] SIF_CLEAR_OFS = 12'h044;
  localparam logic [11:0] SIF_MASK_OFS = 12'h048;
  localparam logic [11:0] SIF_IRQ_OFS = 12'h04C;
  localparam logic [31:0] SIF_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] SIF_MASK_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Flag layout
  // ----------------------------------------------------------------------
  localparam int SIF_NUM_CH = 16;
  localparam int SIF_NUM_FLAGS = 23;
  localparam int SIF_SCAN_BIT = 16;
  localparam int SIF_DEC_BIT = 17;
  localparam int SIF_DECODER_ERROR_FLAG_BIT = 18;
  localparam int SIF_DATAV_BIT = 19;
  localparam int SIF_LEVEL_BIT = 20;
  localparam int SIF_BUFFER_OVERFLOW_FLAG_BIT = 21;
  localparam int SIF_COUNTER_OVERFLOW_FLAG_BIT = 22;

  // AXI4-Lite response codes.
  localparam logic [1:0] SIF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SIF_RESP_SLVERR = 2'h2;

  // Event pulses from the sensing datapath.
  typedef struct packed {
    logic counter_overflow;
    logic buffer_overflow;
    logic buffer_full;
    logic data_available;
    logic decoder_error;
    logic decoder_request;
    logic scan_done;
    logic [15:0] channel_trigger;
  } sif_events_t;

endpackage : sif_pkg

// >>> sif_flag_bank.sv
`timescale 1ns/1ns
// Sticky flag bank: hardware sets, write-one clears, set wins over clear.
module sif_flag_bank
  import sif_pkg::*;
#(
  parameter int WIDTH = 23
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Set and clear vectors.
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clear_i,
  // Flag state.
  output logic [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // Next flags: clear first, then set so a coincident event survives.
  always_comb begin
    flags_next = (flags_reg & ~clear_i) | set_i;
  end

  // Flag storage, zero after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= SIF_FLAGS_RST[WIDTH-1:0];
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule : sif_flag_bank

// >>> sif_irq_flags.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// Interrupt flag capture for the sensor interface with an AXI4-Lite slave.
module sif_irq_flags
  import sif_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Event pulses from the sensing datapath.
  input wire sif_events_t events_i,
  // AXI4-Lite write address channel.
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address channel.
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt.
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Applies byte strobes to a write word.
  function automatic logic [31:0] sif_strobe(input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : sif_strobe

  // Widens a flag vector to a bus word with zero upper bits.
  function automatic logic [31:0] sif_word(input logic [SIF_NUM_FLAGS-1:0] v);
    return {{(32 - SIF_NUM_FLAGS){1'b0}}, v};
  endfunction : sif_word

  // Word-aligned register offset; the two low address bits select nothing.
  function automatic logic [11:0] sif_align(input logic [11:0] addr);
    return {addr[11:2], 2'b00};
  endfunction : sif_align

  // ----------------------------------------------------------------------
  // Event mapping
  // ----------------------------------------------------------------------
  logic [SIF_NUM_FLAGS-1:0] set_vec;
  logic [SIF_NUM_FLAGS-1:0] clear_vec;
  logic [SIF_NUM_FLAGS-1:0] flags;

  // Places each event pulse at its flag position.
  always_comb begin
    set_vec = '0;
    set_vec[SIF_COUNTER_OVERFLOW_FLAG_BIT] = events_i.counter_overflow;
    set_vec[SIF_BUFFER_OVERFLOW_FLAG_BIT] = events_i.buffer_overflow;
    set_vec[SIF_LEVEL_BIT] = events_i.buffer_full;
    set_vec[SIF_DATAV_BIT] = events_i.data_available;
    set_vec[SIF_DECODER_ERROR_FLAG_BIT] = events_i.decoder_error;
    set_vec[SIF_DEC_BIT] = events_i.decoder_request;
    set_vec[SIF_SCAN_BIT] = events_i.scan_done;
    set_vec[SIF_NUM_CH-1:0] = events_i.channel_trigger;
  end

  sif_flag_bank #(
    .WIDTH(SIF_NUM_FLAGS)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(set_vec),
    .clear_i(clear_vec),
    .flags_o(flags)
  );

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic aw_full_reg;
  logic aw_full_next;
  logic [11:0] aw_addr_reg;
  logic [11:0] aw_addr_next;
  logic w_full_reg;
  logic w_full_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic [SIF_NUM_FLAGS-1:0] mask_reg;
  logic [SIF_NUM_FLAGS-1:0] mask_next;
  logic do_write;

  assign s_axi_awready_o = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_full_reg && !bvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  // Holds address and data until both are present, then commits the write.
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    mask_next = mask_reg;
    clear_vec = '0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full_next = 1'b1;
      w_data_next = sif_strobe(s_axi_wdata_i, s_axi_wstrb_i);
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = SIF_RESP_OKAY;
      unique case (sif_align(aw_addr_reg))
        SIF_CLEAR_OFS: clear_vec = w_data_reg[SIF_NUM_FLAGS-1:0];
        SIF_MASK_OFS: mask_next = w_data_reg[SIF_NUM_FLAGS-1:0];
        SIF_FLAGS_OFS, SIF_IRQ_OFS: bresp_next = SIF_RESP_OKAY;
        default: bresp_next = SIF_RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
  end

  // Write channel registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= SIF_RESP_OKAY;
      mask_reg <= SIF_MASK_RST[SIF_NUM_FLAGS-1:0];
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      mask_reg <= mask_next;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  assign s_axi_arready_o = !rvalid_reg;

  // Captures read data on address acceptance and holds it until taken.
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rresp_next = SIF_RESP_OKAY;
      unique case (sif_align(s_axi_araddr_i))
        SIF_FLAGS_OFS: rdata_next = sif_word(flags);
        SIF_CLEAR_OFS: rdata_next = 32'h0000_0000;
        SIF_MASK_OFS: rdata_next = sif_word(mask_reg);
        SIF_IRQ_OFS: rdata_next = sif_word(flags & mask_reg);
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = SIF_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
  end

  // Read channel registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= SIF_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  logic irq_reg;
  logic irq_next;

  // Interrupt level, high while any unmasked flag is set.
  always_comb begin
    irq_next = |(flags & mask_reg);
  end

  // Registered so that the pin cannot glitch while flags and mask change together.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

endmodule : sif_irq_flags

// >>> sif_events_model.sv
`timescale 1ns/1ns
// Sensing datapath stand-in: each request becomes a one-cycle event pulse.
module sif_events_model
  import sif_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests and pulses.
  input wire sif_events_t fire_i,
  output sif_events_t events_o
);
  sif_events_t last_reg;
  sif_events_t last_next;
  // Remember the request so that a held level pulses once.
  always_comb begin
    last_next = rst_i ? '0 : fire_i;
  end
  always_ff @(posedge clk_i) begin
    last_reg <= last_next;
  end
  // Pulse only in the first cycle of a request.
  assign events_o = fire_i & ~last_reg;
endmodule : sif_events_model

// >>> sif_irq_flags_properties.sv
`timescale 1ns/1ns
// Bus and interrupt relations seen at the block's ports.
module sif_irq_flags_properties (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Write channels.
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // Read channels.
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt.
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RST: assert property (disable iff (1'b0) rst_i |=> !irq_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("reset left an answer or irq");
  AST_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:23] == 9'h000)
    else $error("upper read bits not zero");
  AST_RLAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  AST_RHOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  AST_ARIDLE: assert property (s_axi_rvalid_o != s_axi_arready_o)
    else $error("arready wrong");
  AST_BLAT: assert property (s_axi_awvalid_i && s_axi_awready_o
    && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write answer late");
  AST_BHOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  AST_BREFUSE: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during answer");
  AST_AWREFUSE: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("second write address taken while one is held");
  // Main scenarios reached.
  cover property (irq_o);
  cover property (s_axi_bvalid_o && s_axi_bready_i);
  cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
endmodule : sif_irq_flags_properties
bind sif_irq_flags sif_irq_flags_properties i_sif_irq_flags_properties (.clk_i(clk_i), .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));

// >>> sif_irq_flags_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the flag bank and its register slave.
module sif_irq_flags_tb import sif_pkg::*; ;
  typedef struct packed {logic [22:0] ev; logic [31:0] clr; logic [31:0] exp;} sif_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sif_events_t fire = '0;
  sif_events_t events;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, rd_d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  int failures = 0, n_tests = 0;
  // Event, clear word, flags left after the clear.
  sif_row_t rows [7] = '{'{23'h400000, 32'h00400000, 32'h0}, '{23'h200000, 32'h00200000, 32'h0},
    '{23'h100000, 32'h00100000, 32'h0}, '{23'h0F0000, 32'h00050000, 32'h000A0000},
    '{23'h00FFFF, 32'h000000FF, 32'h0000FF00}, '{23'h7FFFFF, 32'h0, 32'h007FFFFF},
    '{23'h7FFFFF, 32'h007FFFFF, 32'h0}};
  // Clock at 50 MHz.
  always #10 clk_i = ~clk_i;
  sif_events_model i_sif_events_model (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .events_o(events));
  sif_irq_flags i_sif_irq_flags (.clk_i(clk_i), .rst_i(rst_i), .events_i(events), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .irq_o(irq));
  // Compare and count.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Write; ev pulses at the edge where address and data are taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [22:0] ev);
    logic ap, wp, bp, ag, wg, bg;
    @(posedge clk_i);
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && bp; n++) begin
      @(negedge clk_i);
      ag = ap && awready;
      wg = wp && wready;
      bg = bvalid === 1'b1;
      wr_r = bresp;
      @(posedge clk_i);
      fire <= (ag && wg) ? ev : '0;
      if (ag) awvalid <= 1'b0;
      if (wg) wvalid <= 1'b0;
      if (bg) bready <= 1'b0;
      ap = ap && !ag;
      wp = wp && !wg;
      bp = !bg;
    end
    if (bp) begin
      failures++;
      give_verdict();
    end
  endtask : wr
  // Read into rd_d and rd_r.
  task automatic rd(input logic [11:0] a);
    logic ap, ag, go;
    @(posedge clk_i);
    ap = 1'b1;
    go = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !go; n++) begin
      @(negedge clk_i);
      ag = ap && arready;
      go = rvalid === 1'b1;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge clk_i);
      if (ag) arvalid <= 1'b0;
      ap = ap && !ag;
      if (go) rready <= 1'b0;
    end
    if (!go) begin
      failures++;
      give_verdict();
    end
  endtask : rd
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SIF_FLAGS_OFS);
    chk("flags_reset", rd_d, SIF_FLAGS_RST);
    foreach (rows[i]) begin
      @(posedge clk_i);
      fire <= rows[i].ev;
      @(posedge clk_i);
      fire <= '0;
      rd(SIF_FLAGS_OFS);
      chk("flags_set", rd_d, {9'h000, rows[i].ev});
      wr(SIF_CLEAR_OFS, rows[i].clr, '0);
      rd(SIF_FLAGS_OFS);
      chk("flags_clear", rd_d, rows[i].exp);
      wr(SIF_CLEAR_OFS, 32'h007FFFFF, '0);
    end
    // A flag register write neither loads nor clears; a clear loses to a coincident event.
    wr(SIF_FLAGS_OFS, 32'h007FFFFF, 23'h000008);
    chk("ro_bresp", wr_r, SIF_RESP_OKAY);
    wr(SIF_CLEAR_OFS, 32'h00000008, 23'h000008);
    wr(SIF_FLAGS_OFS, 32'h00000008, '0);
    rd(SIF_FLAGS_OFS);
    chk("flags_ro_and_set_wins", rd_d, 32'h00000008);
    wr(SIF_MASK_OFS, 32'h00000001, 23'h000003);
    repeat (3) @(negedge clk_i);
    chk("irq_raised", irq, 32'h1);
    rd(SIF_IRQ_OFS);
    chk("masked_flags", rd_d, 32'h00000001);
    wr(SIF_CLEAR_OFS, 32'h00000001, '0);
    repeat (2) @(negedge clk_i);
    chk("irq_masked", irq, 32'h0);
    rd(12'h100);
    chk("unmapped_resp", rd_r, SIF_RESP_SLVERR);
    wr(12'h100, 32'h00000000, '0);
    chk("unmapped_bresp", wr_r, SIF_RESP_SLVERR);
    // Only the strobed byte of a clear word acts.
    @(posedge clk_i);
    fire <= 23'h00FFFF;
    @(posedge clk_i);
    fire <= '0;
    wstrb <= 4'h2;
    wr(SIF_CLEAR_OFS, 32'h0000FFFF, '0);
    wstrb <= 4'hF;
    rd(SIF_FLAGS_OFS);
    chk("strobe_clear", rd_d, 32'h000000FF);
    // A reset in mid-run returns flags, mask and interrupt to zero.
    wr(SIF_MASK_OFS, 32'h007FFFFF, 23'h000010);
    @(negedge clk_i);
    chk("irq_before_reset", irq, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("irq_after_reset", irq, 32'h0);
    rd(SIF_FLAGS_OFS);
    chk("flags_after_reset", rd_d, SIF_FLAGS_RST);
    rd(SIF_MASK_OFS);
    chk("mask_after_reset", rd_d, SIF_MASK_RST);
    give_verdict();
  end
endmodule : sif_irq_flags_tb
